// [src/lnr_nak_reporter.sv]
// negative-acknowledge generator and link activity indicators
// assumes framing/parsing logic on mclk supplies check results at message end
// Notes on behaviour
// - receive indicator flashes while bytes arrive, regardless of sending
// - send indicator flashes while bytes go out; both dark when idle
// - error code goes out as two ascii hex digits, 02H through 0FH
// - several errors at once: only the lowest code is reported
// - any error taken while no reply is under way resets the whole transfer sequence, dropping the message
// - computed sum differs from received sum: code 02H
// - wrong or partly wrong control procedure: code 03H
// - command absent from configured procedure: code 03H
module lnr_nak_reporter
    import lnr_pkg::*;
#(
    parameter int LED_HOLD = lnr_pkg::LED_HOLD_CYC
) (
    input  wire logic                    mclk,
    input  wire logic                    srst,
    input  wire logic                    rxByteStb,
    input  wire logic                    msgEnd,
    input  wire logic [7:0]              sumCalc,
    input  wire logic [7:0]              sumRecv,
    input  wire logic                    procMismatch,
    input  wire logic                    cmdUnknown,
    input  wire logic [lnr_pkg::ERR_COUNT-1:0] extraErr,
    input  wire logic [7:0]              stationNum,
    input  wire logic [7:0]              controllerNum,
    output logic [7:0]                   txData,
    output logic                         txValid,
    input  wire logic                    txReady,
    output logic                         seqReset,
    output logic [7:0]                   nakCode,
    output logic                         rxLed,
    output logic                         sendActivityIndicator
);
    import lnr_pkg::*;

    // error vector: bit n means code n; extra inputs give codes 8 and up
    wire [15:0] errVec;
    wire        sumErr   = sumCalc != sumRecv;
    wire        protoErr = procMismatch | cmdUnknown;
    assign errVec = {extraErr, 4'h0, protoErr, sumErr, 2'h0};

    // lowest set bit wins
    logic [7:0] lowCode;
    always_comb begin
        lowCode = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            if (errVec[i]) begin
                lowCode = 8'(i);
            end
        end
    end
    wire anyErr = msgEnd && (errVec != 16'h0000);

    function automatic logic [7:0] hexAscii(input logic [3:0] n);
        hexAscii = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    lnr_state_t  state_q;
    lnr_state_t  state_d;
    logic [2:0]  idx_q;
    logic [7:0]  code_q;
    logic [7:0]  stn_q;
    logic [7:0]  ctl_q;

    // ascii digits of the captured reply fields
    wire [7:0] stnHiChar  = hexAscii(stn_q[7:4]);
    wire [7:0] stnLoChar  = hexAscii(stn_q[3:0]);
    wire [7:0] ctlHiChar  = hexAscii(ctl_q[7:4]);
    wire [7:0] ctlLoChar  = hexAscii(ctl_q[3:0]);
    wire [7:0] codeHiChar = hexAscii(code_q[7:4]);
    wire [7:0] codeLoChar = hexAscii(code_q[3:0]);

    // reply: nak, station(2), controller(2), code(2)
    logic [7:0] byteSel;
    always_comb begin
        case (idx_q)
            3'd0: begin
                byteSel = CHAR_NAK;
            end
            3'd1: begin
                byteSel = stnHiChar;
            end
            3'd2: begin
                byteSel = stnLoChar;
            end
            3'd3: begin
                byteSel = ctlHiChar;
            end
            3'd4: begin
                byteSel = ctlLoChar;
            end
            3'd5: begin
                byteSel = codeHiChar;
            end
            default: begin
                byteSel = codeLoChar;
            end
        endcase
    end

    wire       txFire    = txValid && txReady;
    wire       lastByte  = idx_q == 3'(NAK_LEN - 1);
    // errors are only taken while no reply is under way
    wire       acceptErr = anyErr && (state_q == ST_IDLE);
    wire [2:0] idxNext   = idx_q + 3'd1;

    always_comb begin
        case (state_q)
            ST_IDLE: state_d = anyErr ? ST_SEND : ST_IDLE;
            ST_SEND: state_d = (txFire && lastByte) ? ST_DONE : ST_SEND;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    assign txValid = state_q == ST_SEND;
    assign txData  = byteSel;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // one-cycle pulse drops the message in progress upstream
    always_ff @(posedge mclk) begin
        if (srst) begin
            seqReset <= 1'b0;
        end else begin
            seqReset <= acceptErr;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            code_q <= 8'h00;
        end else if (acceptErr) begin
            code_q <= lowCode;
        end
    end

    // last reported code stays until the next accepted error
    always_ff @(posedge mclk) begin
        if (srst) begin
            nakCode <= 8'h00;
        end else if (acceptErr) begin
            nakCode <= lowCode;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            stn_q <= 8'h00;
        end else if (acceptErr) begin
            stn_q <= stationNum;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctl_q <= 8'h00;
        end else if (acceptErr) begin
            ctl_q <= controllerNum;
        end
    end

    // byte position; restarts at every accepted error
    always_ff @(posedge mclk) begin
        if (srst) begin
            idx_q <= 3'd0;
        end else if (acceptErr) begin
            idx_q <= 3'd0;
        end else if (txFire) begin
            idx_q <= idxNext;
        end
    end

    lnr_activity_led #(.HOLD(LED_HOLD)) uRxLed (
        .mclk   (mclk),
        .srst   (srst),
        .strobe (rxByteStb),
        .led    (rxLed)
    );
    lnr_activity_led #(.HOLD(LED_HOLD)) uTxLed (
        .mclk   (mclk),
        .srst   (srst),
        .strobe (txFire),
        .led    (sendActivityIndicator)
    );
endmodule

// [src/lnr_pkg.sv]
// package for the link negative-acknowledge error reporter
// assumes a single 200 MHz clock domain and ascii framing bytes
package lnr_pkg;
    localparam int CLK_MHZ = 200;
    // indicator hold after each byte, in microseconds
    localparam int LED_HOLD_US = 20;
    localparam int LED_HOLD_CYC = LED_HOLD_US * CLK_MHZ;
    localparam logic [7:0] ERR_SUM_CHECK = 8'h02;
    localparam logic [7:0] ERR_PROTOCOL = 8'h03;
    localparam logic [7:0] CHAR_NAK = 8'h15;
    localparam int ERR_COUNT = 8;
    localparam int NAK_LEN = 7;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_DONE = 3'b100
    } lnr_state_t;
endpackage

// [src/lnr_activity_led.sv]
// stretches byte strobes into a visible flashing indicator
// assumes strobe is already synchronous to mclk
module lnr_activity_led #(
    parameter int HOLD = lnr_pkg::LED_HOLD_CYC
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic strobe,
    output logic      led
);
    localparam int CW = $clog2(HOLD + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    assign cnt_d = strobe ? CW'(HOLD) : (cnt_q != '0 ? cnt_q - 1'b1 : cnt_q);
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= '0;
            led   <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            led   <= cnt_d != '0;
        end
    end
endmodule

// [testbench/lnr_nak_properties.sv]
// port checker for the nak reporter
// assumes a bind onto lnr_nak_reporter, one clock
module lnr_nak_properties (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       rxByteStb,
    input wire logic       msgEnd,
    input wire logic [7:0] sumCalc,
    input wire logic [7:0] sumRecv,
    input wire logic       procMismatch,
    input wire logic       cmdUnknown,
    input wire logic [7:0] txData,
    input wire logic       txValid,
    input wire logic       txReady,
    input wire logic       seqReset,
    input wire logic [7:0] nakCode,
    input wire logic       rxLed,
    input wire logic       sendActivityIndicator
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_reset_cause: assert property (seqReset |-> $past(msgEnd)) else $error("stray reset");
    a_reset_once: assert property (seqReset |=> !seqReset) else $error("long reset");
    a_sum_code: assert property (seqReset && $past(sumCalc != sumRecv) |-> nakCode == 8'h02)
        else $error("bad sum code");
    a_proto_code: assert property (seqReset && $past(sumCalc == sumRecv && (procMismatch
        || cmdUnknown)) |-> nakCode == 8'h03) else $error("bad proto code");
    a_reply_head: assert property (seqReset |-> txValid && txData == 8'h15) else $error("no nak");
    a_reply_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("byte dropped");
    a_rx_flash: assert property (rxByteStb |=> rxLed) else $error("rx dark");
    a_tx_flash: assert property (txValid && txReady |=> sendActivityIndicator) else $error("tx dark");
endmodule

bind lnr_nak_reporter lnr_nak_properties chk_u (.mclk, .srst, .rxByteStb, .msgEnd, .sumCalc,
    .sumRecv, .procMismatch, .cmdUnknown, .txData, .txValid, .txReady, .seqReset, .nakCode,
    .rxLed, .sendActivityIndicator);

// [testbench/lnr_host_model.sv]
// host model taking reply bytes, prompt or every other cycle
// assumes txValid holds until a byte is taken
module lnr_host_model (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic slow,
    output logic      txReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q;
    always_ff @(posedge mclk) tog_q <= srst ? 1'b0 : !tog_q;
    assign txReady = !slow || tog_q;
endmodule

// [testbench/testbench.sv]
// self-checking bench for the nak reporter
// assumes LED_HOLD of 4 and the host model on the reply side
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, srst = 1, rxByteStb = 0, msgEnd = 0, procMismatch = 0, cmdUnknown = 0;
    logic [7:0] sumCalc = '0, sumRecv = '0, extraErr = '0, txData, nakCode, got [7];
    logic [7:0] stn = '0, ctl = '0;
    logic txValid, txReady, seqReset, rxLed, sendAct, slow = 0;
    int errors = 0, total_checks = 0;
    always #2.5 mclk = ~mclk;
    lnr_nak_reporter #(.LED_HOLD(4)) dut_u (.mclk, .srst, .rxByteStb, .msgEnd, .sumCalc,
        .sumRecv, .procMismatch, .cmdUnknown, .extraErr, .stationNum(stn), .controllerNum(ctl),
        .txData, .txValid, .txReady, .seqReset, .nakCode, .rxLed, .sendActivityIndicator(sendAct));
    lnr_host_model host_u (.mclk, .srst, .slow, .txReady);
    task automatic check8(input logic [7:0] act, input logic [7:0] exp);
        total_checks++;
        if (act !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, act, exp);
        end
    endtask
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'hA ? 8'h30 + n : 8'h37 + n;
    endfunction
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic nak(input logic [7:0] st, input logic [7:0] ct, input logic [7:0] code);
        int n;
        logic [55:0] exp;
        n = 0;
        exp = {8'h15, hx(st[7:4]), hx(st[3:0]), hx(ct[7:4]), hx(ct[3:0]), hx(code[7:4]), hx(code[3:0])};
        repeat (2) @(negedge mclk);
        {msgEnd, stn, ctl} = {1'b1, st, ct};
        @(negedge mclk);
        msgEnd = 0;
        check8({7'h00, seqReset}, 8'h01);
        check8(nakCode, code);
        for (int i = 0; i < 60 && n < 7; i++) begin
            if (txValid === 1'b1 && txReady === 1'b1) got[n++] = txData;
            @(negedge mclk);
        end
        check8({7'h00, sendAct}, 8'h01);
        if (n < 7) begin
            errors++;
            summarize();
        end
        for (int i = 0; i < 7; i++) check8(got[i], exp[55-8*i -: 8]);
        {sumCalc, procMismatch, cmdUnknown, extraErr} = '0;
    endtask
    task automatic t_codes;
        {slow, sumRecv, procMismatch, extraErr} = {1'b1, 8'h34, 1'b1, 8'h81};
        nak(8'h00, 8'hFF, 8'h02);
        {slow, sumRecv} = {1'b0, 8'h00};
        procMismatch = 1;
        nak(8'hA5, 8'h3C, 8'h03);
        {sumRecv, cmdUnknown} = {8'h00, 1'b1};
        nak(8'hFF, 8'h09, 8'h03);
        extraErr = 8'h50;
        nak(8'h12, 8'hE7, 8'h0C);
        $display("t_codes done");
    endtask
    task automatic t_quiet;
        repeat (8) @(negedge mclk);
        {msgEnd, rxByteStb} = 2'b11;
        @(negedge mclk);
        {msgEnd, rxByteStb} = 2'b00;
        check8({6'h00, seqReset, txValid}, 8'h00);
        check8({6'h00, rxLed, sendAct}, 8'h02);
        repeat (12) @(negedge mclk);
        check8({6'h00, rxLed, sendAct}, 8'h00);
        $display("t_quiet done");
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        srst = 0;
        t_codes();
        t_quiet();
        summarize();
    end
endmodule
